// File: src/eeprom_seq_read.sv
// two-wire eeprom slave: address load, current/random/streaming reads
`timescale 1ns/100ps
`include "eeprom_rd_regs.svh"
module eeprom_seq_read #(
  parameter int ADDR_W = `EE_ADDR_W,
  parameter logic [2:0] DEV_ADDR = 3'h0 // arbitrary select bits
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic standby_o,
  output logic [ADDR_W-1:0] addr_o
);
  localparam int DEPTH = 1 << ADDR_W;

  eeprom_rd_pkg::bus_ev_t ev;
  eeprom_rd_pkg::slv_state_t state_q;
  logic [`EE_BIT_CNT_W-1:0] bit_q;
  logic [7:0] shf_q;
  logic [ADDR_W-1:0] addr_q;
  logic [1:0] abyte_q;
  logic [7:0] ahi_q;
  logic rw_q;
  logic sda_q;
  logic [7:0] mem [DEPTH];

  // ******************************************************************
  // pin conditioning
  // ******************************************************************
  i2c_pin_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .ev_o(ev)
  );

  // ******************************************************************
  // array
  // ******************************************************************
  // no write path here: contents stay at the erased value
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = `EE_ERASED_BYTE; // see (R8)
    end
  end

  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
    next_addr = a + 1'b1; // natural overflow wraps top to zero, see (R5)
  endfunction

  // ******************************************************************
  // protocol sequencer
  // ******************************************************************
  // start wins over everything; stop returns to idle holding the pointer
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= eeprom_rd_pkg::ST_IDLE;
      bit_q <= '0;
      shf_q <= 8'h00;
      rw_q <= 1'b0;
      abyte_q <= 2'h0;
      ahi_q <= 8'h00;
      addr_q <= '0;
    end else if (ev.start) begin
      state_q <= eeprom_rd_pkg::ST_DEV;
      bit_q <= '0;
      abyte_q <= 2'h0;
    end else if (ev.stop) begin
      state_q <= eeprom_rd_pkg::ST_IDLE; // pointer kept, see (R9)
    end else begin
      case (state_q)
        eeprom_rd_pkg::ST_DEV, eeprom_rd_pkg::ST_ADRW: begin
          if (ev.scl_rise) begin
            shf_q <= {shf_q[6:0], ev.sda};
            bit_q <= bit_q + 1'b1;
          end
          if (ev.scl_fall && bit_q == `EE_ACK_BIT) begin
            bit_q <= '0;
            if (state_q == eeprom_rd_pkg::ST_DEV) begin
              if (shf_q[7:1] == {`EE_DEV_TYPE, DEV_ADDR}) begin
                rw_q <= shf_q[0];
                state_q <= eeprom_rd_pkg::ST_ACK;
              end else begin
                state_q <= eeprom_rd_pkg::ST_IDLE;
              end
            end else if (abyte_q == 2'h0) begin
              ahi_q <= shf_q;
              abyte_q <= 2'h1;
              state_q <= eeprom_rd_pkg::ST_ACK;
            end else begin
              // new address loaded; random read follows via restart, see (R1)
              addr_q <= ADDR_W'({ahi_q, shf_q});
              abyte_q <= 2'h2;
              state_q <= eeprom_rd_pkg::ST_ACK;
            end
          end
        end
        eeprom_rd_pkg::ST_ACK: begin
          // our ack occupies one clock; next falling edge ends it
          if (ev.scl_fall) begin
            if (rw_q) begin
              shf_q <= mem[addr_q]; // held pointer read, see (R1)
              state_q <= eeprom_rd_pkg::ST_SEND;
            end else if (abyte_q == 2'h2) begin
              state_q <= eeprom_rd_pkg::ST_IDLE; // write data unsupported
            end else begin
              state_q <= eeprom_rd_pkg::ST_ADRW;
            end
          end
        end
        eeprom_rd_pkg::ST_SEND: begin
          if (ev.scl_fall) begin
            shf_q <= {shf_q[6:0], 1'b1};
            bit_q <= bit_q + 1'b1;
            if (bit_q == `EE_LAST_BIT) begin
              addr_q <= next_addr(addr_q); // see (R4)
              bit_q <= '0;
              state_q <= eeprom_rd_pkg::ST_MACK;
            end
          end
        end
        eeprom_rd_pkg::ST_MACK: begin
          // line released; sample master's answer on the ninth rise
          if (ev.scl_rise) begin // see (R6)
            if (!ev.sda) begin
              shf_q <= mem[addr_q]; // see (R2)
            end else begin
              state_q <= eeprom_rd_pkg::ST_IDLE; // see (R7)
            end
          end
          if (ev.scl_fall) begin
            state_q <= eeprom_rd_pkg::ST_SEND;
          end
        end
        default: begin
          state_q <= eeprom_rd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ******************************************************************
  // pin drive
  // ******************************************************************
  // registered drive; open drain so only low is actively driven
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sda_q <= 1'b1;
    end else begin
      case (state_q)
        eeprom_rd_pkg::ST_ACK: sda_q <= 1'b0;
        eeprom_rd_pkg::ST_SEND: sda_q <= shf_q[7];
        default: sda_q <= 1'b1; // released in master ack slot, see (R6)
      endcase
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = !sda_q;
  assign standby_o = (state_q == eeprom_rd_pkg::ST_IDLE);
  assign addr_o = addr_q;

  // ******************************************************************
  // checks
  // ******************************************************************
  property p_release_ack;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (state_q == eeprom_rd_pkg::ST_MACK) |=> !sda_oe_o;
  endproperty
  a_release_ack: assert property (p_release_ack) else $error("line driven in ack slot"); // (R6)

  property p_nack_idle;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (state_q == eeprom_rd_pkg::ST_MACK && ev.scl_rise && ev.sda && !ev.stop && !ev.start)
      |=> standby_o ##1 !sda_oe_o;
  endproperty
  a_nack_idle: assert property (p_nack_idle) else $error("no standby after nack"); // (R7)

  property p_ack_next;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (state_q == eeprom_rd_pkg::ST_MACK && ev.scl_fall && !ev.stop && !ev.start)
      |=> state_q == eeprom_rd_pkg::ST_SEND;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("next byte not sent"); // (R2)

  property p_incr;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (state_q == eeprom_rd_pkg::ST_SEND ##1 state_q == eeprom_rd_pkg::ST_MACK)
      |-> addr_q == next_addr($past(addr_q));
  endproperty
  a_incr: assert property (p_incr) else $error("address not incremented"); // (R4)

  property p_wrap;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      ($rose(state_q == eeprom_rd_pkg::ST_MACK) && $past(&addr_q)) |-> addr_q == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("address did not wrap"); // (R5)

  property p_stop_hold;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (ev.stop && !ev.start) |=> standby_o && $stable(addr_q);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop lost pointer"); // (R9)

  property p_ff_data;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (state_q == eeprom_rd_pkg::ST_SEND) |=> sda_q;
  endproperty
  a_ff_data: assert property (p_ff_data) else $error("erased byte not ones"); // (R8)

  property p_cur_read;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (state_q == eeprom_rd_pkg::ST_ACK && rw_q && ev.scl_fall && !ev.start && !ev.stop)
      |=> state_q == eeprom_rd_pkg::ST_SEND;
  endproperty
  a_cur_read: assert property (p_cur_read) else $error("read not entered"); // (R1)

  c_nack: cover property (@(posedge sys_clk_i) state_q == eeprom_rd_pkg::ST_MACK ##1 standby_o);
  c_stream: cover property (@(posedge sys_clk_i)
    state_q == eeprom_rd_pkg::ST_MACK ##1 state_q == eeprom_rd_pkg::ST_SEND);
  c_wrap: cover property (@(posedge sys_clk_i) (&addr_q) ##1 addr_q == '0);
endmodule // eeprom_seq_read

// File: src/eeprom_rd_regs.svh
// timing counts, widths and fixed values of the streaming read slave
// Functional notes
// (R1) stream starts from held or newly loaded address
// (R2) master ack makes device send next byte
// (R3) master ends stream with nack then STOP
// (R4) address counter increments after every output byte
// (R5) counter wraps from top location to zero
// (R6) release data line, sample ack on ninth clock
// (R7) no ack: stop driving, enter standby
// (R8) unwritten memory reads back as FFh
// (R9) after STOP keep address, wait for START
`ifndef EEPROM_RD_REGS_SVH
`define EEPROM_RD_REGS_SVH
`define EE_ADDR_W 15
`define EE_DEV_TYPE 4'hA
`define EE_ERASED_BYTE 8'hFF
`define EE_BIT_CNT_W 4
`define EE_ACK_BIT 4'h8
`define EE_LAST_BIT 4'h7
`endif

// File: src/eeprom_rd_pkg.sv
// types shared by the streaming read slave
package eeprom_rd_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_DEV = 6'b000010,
    ST_ACK = 6'b000100,
    ST_ADRW = 6'b001000,
    ST_SEND = 6'b010000,
    ST_MACK = 6'b100000
  } slv_state_t;
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } bus_ev_t;
endpackage

// File: src/i2c_pin_sync.sv
// pin synchroniser and bus condition detector
`timescale 1ns/100ps
`include "eeprom_rd_regs.svh"
module i2c_pin_sync (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output eeprom_rd_pkg::bus_ev_t ev_o
);
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic scl_s_q;
  logic sda_s_q;

  // three-stage chain; stage 0 feeds only stage 1
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
    end
  end

  // a change counts only once stages 1 and 2 agree, filtering one-cycle glitches
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_s_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      if (scl_q[1] == scl_q[2]) begin
        scl_s_q <= scl_q[2];
      end
      if (sda_q[1] == sda_q[2]) begin
        sda_s_q <= sda_q[2];
      end
    end
  end

  // edges and conditions; sda moving while scl high is start or stop
  always_comb begin
    ev_o.scl_rise = !scl_s_q && (scl_q[1] == scl_q[2]) && scl_q[2];
    ev_o.scl_fall = scl_s_q && (scl_q[1] == scl_q[2]) && !scl_q[2];
    ev_o.start = scl_s_q && sda_s_q && (sda_q[1] == sda_q[2]) && !sda_q[2];
    ev_o.stop = scl_s_q && !sda_s_q && (sda_q[1] == sda_q[2]) && sda_q[2];
    ev_o.sda = sda_s_q;
  end
endmodule // i2c_pin_sync

// File: bench/i2c_master_model.sv
// bus master model that drives the two-wire lines for the streaming read bench
`timescale 1ns/100ps
module i2c_master_model (
  input wire logic sys_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // ****
  // line control
  // ****
  // bus idle: both lines released high
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // a quarter bit is 5 system clocks, above the 3-clock pin filter
  task automatic step(input logic c, input logic d);
    scl_o = c;
    sda_o = d;
    repeat (5) @(negedge sys_clk_i);
  endtask
  // start, or repeated start when the clock is already low
  task automatic start();
    step(scl_o, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  // only issued after a byte left unacknowledged
  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  // nine bit times; the ninth carries the acknowledge either way
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      step(1'b0, tx[i]);
      step(1'b1, tx[i]);
      rx[i] = sda_i;
      step(1'b1, tx[i]);
      step(1'b0, tx[i]);
    end
  endtask
endmodule // i2c_master_model

// File: bench/eeprom_seq_read_tb.sv
// self-checking bench for the streaming read slave
`timescale 1ns/100ps
module eeprom_seq_read_tb;
  logic sys_clk_i;
  logic reset_n_i;
  logic scl;
  logic sda_m;
  logic dev_sda;
  logic sda_oe;
  logic standby;
  logic [14:0] addr;
  logic sda_bus;
  int failures = 0;
  int num_checks = 0;
  // wired-and with a pull-up: released lines read high
  assign sda_bus = sda_m & (sda_oe ? dev_sda : 1'b1);
  eeprom_seq_read u_eeprom_seq_read (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .scl_i(scl),
    .sda_i(sda_bus),
    .sda_o(dev_sda),
    .sda_oe_o(sda_oe),
    .standby_o(standby),
    .addr_o(addr)
  );
  i2c_master_model u_i2c_master_model (
    .sys_clk_i(sys_clk_i),
    .sda_i(sda_bus),
    .scl_o(scl),
    .sda_o(sda_m)
  );
  // ****
  // checking and closing
  // ****
  task automatic check(input logic [14:0] seen, input logic [14:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  // read n bytes from start address a, acking all but the last, then stop
  task automatic read_run(input int n, input logic [14:0] a);
    logic [8:0] rx;
    u_i2c_master_model.xfer({8'hA1, 1'b1}, rx);
    check({14'h0000, rx[0]}, 15'h0000, "read control ack");
    for (int i = 0; i < n; i++) begin
      u_i2c_master_model.xfer({8'hFF, i == n - 1}, rx);
      a = a + 15'h0001;
      check({7'h00, rx[8:1]}, 15'h00FF, "erased byte");
      check(addr, a, "counter step");
      check({14'h0000, standby}, {14'h0000, i == n - 1}, "stream state");
    end
    check({14'h0000, rx[0]}, 15'h0001, "line released in ack slot");
    check({14'h0000, sda_oe}, 15'h0000, "no drive after nack");
    u_i2c_master_model.stop();
    check({14'h0000, standby}, 15'h0001, "standby after stop");
    check(addr, a, "counter kept");
  endtask
  // addressed read near the top of the array, crossing the wrap
  task automatic test_random_read();
    logic [8:0] rx;
    u_i2c_master_model.start();
    u_i2c_master_model.xfer({8'hA0, 1'b1}, rx);
    check({14'h0000, rx[0]}, 15'h0000, "write control ack");
    u_i2c_master_model.xfer({8'h7F, 1'b1}, rx);
    u_i2c_master_model.xfer({8'hFE, 1'b1}, rx);
    check({14'h0000, rx[0]}, 15'h0000, "address ack");
    u_i2c_master_model.start();
    read_run(4, 15'h7FFE);
  endtask
  // a foreign select code is refused: no acknowledge, pointer left alone
  task automatic test_wrong_select();
    logic [8:0] rx;
    u_i2c_master_model.start();
    u_i2c_master_model.xfer({8'hA3, 1'b1}, rx);
    check({14'h0000, rx[0]}, 15'h0001, "foreign code not acked");
    check({14'h0000, standby}, 15'h0001, "standby after foreign code");
    u_i2c_master_model.stop();
    check(addr, 15'h0002, "pointer after foreign code");
  endtask
  // read from the held pointer left by the previous stream
  task automatic test_current_read();
    u_i2c_master_model.start();
    read_run(2, 15'h0002);
  endtask
  // ****
  // clock, reset, sequence, watchdog
  // ****
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // reset stands in for power-on; the outputs are checked while it is held
  initial begin
    reset_n_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    check({13'h0000, standby, sda_oe}, 15'h0002, "reset state");
    check(addr, 15'h0000, "reset address");
    reset_n_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    test_random_read();
    test_wrong_select();
    test_current_read();
    print_verdict();
  end
  // a full run takes about 2300 clocks; allow about twenty times that
  initial begin
    #200000;
    failures++;
    print_verdict();
  end
endmodule // eeprom_seq_read_tb
